/* File: common/ckrs_pkg.sv */
// Purpose: shared constants and types for the clock and reset source
// Assumes: 25 MHz system clock
// Notes: register map is a small private map on the plain command port
`default_nettype none
package ckrs_pkg;
   localparam int unsigned SYS_CLK_MHZ = 25;
   localparam int unsigned CLK_RATE_MHZ_DEFAULT = 10;
   localparam int unsigned INIT_RST_CYCLES_DEFAULT = 0;
   localparam logic RST_HIGH_DEFAULT = 1'b1;
   // offsets
   localparam logic [3:0] REG_CTRL_OFS = 4'h0;
   localparam logic [3:0] REG_CFG_OFS = 4'h4;
   localparam logic [3:0] REG_INIT_OFS = 4'h8;
   localparam logic [3:0] REG_STAT_OFS = 4'hc;
   // control bits (write one to act)
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_HALT_BIT = 1;
   localparam int unsigned CTRL_RAISE_BIT = 2;
   localparam int unsigned CTRL_RELEASE_BIT = 3;
   // config fields
   localparam int unsigned CFG_RATE_LSB = 0;
   localparam int unsigned CFG_POL_BIT = 8;
   // status fields
   localparam int unsigned STAT_RUN_BIT = 0;
   localparam int unsigned STAT_RST_BIT = 1;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ckrs_req_t;
endpackage
`default_nettype wire

/* File: rtl/ckrs_top.sv */
// Purpose: controllable clock output and configurable reset output
// Assumes: synchronous active high reset; 25 MHz clk_i; commands on plain port
// Notes: output clock derived by divider, so rates above 12 MHz saturate
`timescale 1ns/10ps
`default_nettype none
module ckrs_top (
   input wire logic clk_i,                 // system clock
   input wire logic reset_i,               // sync reset, high
   input wire ckrs_pkg::ckrs_req_t req_i,  // command port
   output logic [31:0] rdata_o,            // read data, cycle after read
   output logic dut_clk_o,                 // generated clock
   output logic dut_rst_o                  // generated reset
);
   import ckrs_pkg::*;

   logic [7:0] rate_reg, rate_next;
   logic pol_reg, pol_next;
   logic [31:0] init_reg, init_next;
   logic [31:0] icnt_reg, icnt_next;
   logic run_reg, run_next;
   logic rst_act_reg, rst_act_next;
   logic hold_reg, hold_next;
   logic [15:0] div_reg, div_next;
   logic clk_reg, clk_next;
   logic rst_reg, rst_next;
   logic [31:0] rdata_reg, rdata_next;

   wire wr_ctrl = req_i.wr && req_i.addr == REG_CTRL_OFS;
   wire wr_cfg = req_i.wr && req_i.addr == REG_CFG_OFS;
   wire wr_init = req_i.wr && req_i.addr == REG_INIT_OFS;
   wire cmd_run = wr_ctrl && req_i.wdata[CTRL_RUN_BIT];
   wire cmd_halt = wr_ctrl && req_i.wdata[CTRL_HALT_BIT];
   wire cmd_raise = wr_ctrl && req_i.wdata[CTRL_RAISE_BIT];
   wire cmd_rel = wr_ctrl && req_i.wdata[CTRL_RELEASE_BIT];

   // half period in system cycles; rate zero treated as one MHz
   wire [7:0] rate_eff = (rate_reg == 8'h00) ? 8'h01 : rate_reg;
   // whole-cycle divider: half period rounds down, so the output settles on the nearest reachable faster rate
   wire [15:0] rate_x2 = {7'h00, rate_eff, 1'b0};
   wire [15:0] half_raw = 16'(SYS_CLK_MHZ) / rate_x2;
   wire [15:0] half_cyc = (half_raw == 16'h0000) ? 16'h0001 : half_raw;
   wire div_end = div_reg >= half_cyc - 16'h0001;

   assign rate_next = wr_cfg ? req_i.wdata[CFG_RATE_LSB +: 8] : rate_reg;
   assign pol_next = wr_cfg ? req_i.wdata[CFG_POL_BIT] : pol_reg;
   assign init_next = wr_init ? req_i.wdata : init_reg;
   // halt wins over run when both bits written together
   assign run_next = cmd_halt ? 1'b0 : (cmd_run ? 1'b1 : run_reg);
   assign div_next = (!run_reg || div_end) ? 16'h0000 : div_reg + 16'h0001;
   // clock parks low while halted
   assign clk_next = !run_reg ? 1'b0 : (div_end ? ~clk_reg : clk_reg);
   // initial hold counts system clock cycles after reset release
   wire hold_now = icnt_reg < init_reg;
   assign hold_next = hold_now;
   assign icnt_next = hold_now ? icnt_reg + 32'h1 : icnt_reg;
   // reset lets go by itself only in the cycle the hold drops
   wire hold_done = hold_reg && !hold_now;
   assign rst_act_next = cmd_raise ? 1'b1 :
                         cmd_rel ? 1'b0 :
                         hold_now ? 1'b1 :
                         hold_done ? 1'b0 :
                         rst_act_reg;
   assign rst_next = pol_reg ? rst_act_reg : ~rst_act_reg;

   wire rd_cfg = req_i.rd && req_i.addr == REG_CFG_OFS;
   wire rd_init = req_i.rd && req_i.addr == REG_INIT_OFS;
   wire rd_stat = req_i.rd && req_i.addr == REG_STAT_OFS;
   wire [31:0] cfg_word = {23'h0, pol_reg, rate_reg};
   wire [31:0] stat_word = {30'h0, rst_act_reg, run_reg};
   // unmapped and idle cycles read as zero
   assign rdata_next = rd_cfg ? cfg_word :
                       rd_init ? init_reg :
                       rd_stat ? stat_word : 32'h0;

   ckrs_dff #(
      .W(8),
      .RST(8'(CLK_RATE_MHZ_DEFAULT))
   ) u_rate (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(rate_next),
      .q_o(rate_reg)
   );

   ckrs_dff #(
      .W(1),
      .RST(RST_HIGH_DEFAULT)
   ) u_pol (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(pol_next),
      .q_o(pol_reg)
   );

   ckrs_dff #(
      .W(32),
      .RST(32'(INIT_RST_CYCLES_DEFAULT))
   ) u_init (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(init_next),
      .q_o(init_reg)
   );

   ckrs_dff #(
      .W(32),
      .RST(32'h0)
   ) u_icnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(icnt_next),
      .q_o(icnt_reg)
   );

   ckrs_dff #(
      .W(1),
      .RST(1'b0)
   ) u_run (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(run_next),
      .q_o(run_reg)
   );

   ckrs_dff #(
      .W(1),
      .RST(1'(INIT_RST_CYCLES_DEFAULT != 0))
   ) u_hold (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(hold_next),
      .q_o(hold_reg)
   );

   ckrs_dff #(
      .W(1),
      .RST(1'(INIT_RST_CYCLES_DEFAULT != 0))
   ) u_rst_act (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(rst_act_next),
      .q_o(rst_act_reg)
   );

   ckrs_dff #(
      .W(16),
      .RST(16'h0000)
   ) u_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(div_next),
      .q_o(div_reg)
   );

   ckrs_dff #(
      .W(1),
      .RST(1'b0)
   ) u_clk (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(clk_next),
      .q_o(clk_reg)
   );

   // output level after reset follows the default polarity
   ckrs_dff #(
      .W(1),
      .RST(1'((INIT_RST_CYCLES_DEFAULT != 0) ~^ RST_HIGH_DEFAULT))
   ) u_rst (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(rst_next),
      .q_o(rst_reg)
   );

   ckrs_dff #(
      .W(32),
      .RST(32'h0)
   ) u_rdata (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(rdata_next),
      .q_o(rdata_reg)
   );

   assign rdata_o = rdata_reg;
   assign dut_clk_o = clk_reg;
   assign dut_rst_o = rst_reg;
endmodule // ckrs_top

// one resettable register; all state of the block goes through it
module ckrs_dff #(
   parameter int unsigned W = 1, // width
   parameter logic [W-1:0] RST = '0 // value after reset
) (
   input wire logic clk_i, // system clock
   input wire logic reset_i, // sync reset, high
   input wire logic [W-1:0] d_i, // next value
   output logic [W-1:0] q_o // registered value
);
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         q_o <= RST;
      end else begin
         q_o <= d_i;
      end
   end
endmodule // ckrs_dff
`default_nettype wire

/* File: sim/ckrs_far_model.sv */
// Purpose: far-side logic on the made clock
// Assumes: bench gives reset polarity
// Notes: counts edges out of reset only
`timescale 1ns/10ps
`default_nettype none
module ckrs_far_model (
   input wire logic clk_i, // made clock
   input wire logic rst_i, // made reset
   input wire logic pol_i, // polarity in use
   output var int edges_o // rising edges out of reset
);
   always @(posedge clk_i) if (rst_i !== pol_i) edges_o <= edges_o + 1;
endmodule // ckrs_far_model
`default_nettype wire

/* File: sim/ckrs_top_asserts.sv */
// Purpose: port checks for ckrs_top
// Assumes: rate left at default
// Notes: polarity mirrored here
`timescale 1ns/10ps
`default_nettype none
module ckrs_top_asserts import ckrs_pkg::*; (
   input wire logic clk_i, // clock
   input wire logic reset_i, // reset
   input wire ckrs_req_t req_i, // commands
   input wire logic [31:0] rdata_o, // read data
   input wire logic dut_clk_o, // made clock
   input wire logic dut_rst_o // made reset
);
   logic pol_reg;
   logic run_reg;
   wire w = req_i.wr, r = req_i.rd, c = w && req_i.addr == REG_CTRL_OFS;
   wire [3:0] a = req_i.addr;
   wire [31:0] d = req_i.wdata;
   wire run = c && d[1:0] == 2'h1, cfg = w && a == REG_CFG_OFS;
   always_ff @(posedge clk_i) pol_reg <= reset_i ? RST_HIGH_DEFAULT : cfg ? d[CFG_POL_BIT] : pol_reg;
   // halt beats run when both are written together
   always_ff @(posedge clk_i) run_reg <= reset_i ? 1'b0 : (c && d[CTRL_HALT_BIT]) ? 1'b0 :
      (c && d[CTRL_RUN_BIT]) ? 1'b1 : run_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   chk_run_on: assert property (run ##1 !w[*3] |=> $changed(dut_clk_o))
      else $error("clock idle");
   chk_halt_low: assert property (c && d[1] ##1 !w[*3] |=> !dut_clk_o)
      else $error("clock on");
   chk_raise: assert property (c && d[2] ##1 !w |=> dut_rst_o == pol_reg)
      else $error("not raised");
   chk_release: assert property (c && d[3:2] == 2'h2 ##1 !w |=> dut_rst_o != pol_reg)
      else $error("not released");
   chk_rd_idle: assert property (!r |=> rdata_o == 32'h0) else $error("stray data");
   chk_unmapped: assert property (r && a[1:0] != 2'h0 |=> rdata_o == 32'h0)
      else $error("unmapped data");
   chk_stat_rst: assert property (r && a == REG_STAT_OFS |=> rdata_o[1] == (dut_rst_o == pol_reg))
      else $error("status reset");
   chk_cfg_pol: assert property (r && a == REG_CFG_OFS |=> rdata_o[8] == pol_reg)
      else $error("polarity");
   chk_stat_run: assert property (r && a == REG_STAT_OFS |=> rdata_o[0] == run_reg)
      else $error("status run");
endmodule // ckrs_top_asserts
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: self-checking bench for ckrs_top
// Assumes: rate left at default
// Notes: reads queue expected data
`timescale 1ns/10ps
`default_nettype none
module testbench import ckrs_pkg::*;;
   logic clk_i = 0;
   logic reset_i = 1;
   logic rq = 0;
   logic pol = 1;
   logic dc, dr;
   logic [31:0] rdata;
   logic [31:0] s = 32'd93095;
   logic [31:0] q[$];
   ckrs_req_t req = '0;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int edges, e0;
   ckrs_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata),
      .dut_clk_o(dc), .dut_rst_o(dr));
   ckrs_far_model u_far (.clk_i(dc), .rst_i(dr), .pol_i(pol), .edges_o(edges));
   always #20 clk_i = ~clk_i;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic results;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req <= '0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      q.push_back(e);
      @(posedge clk_i);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req <= '0;
   endtask
   always @(posedge clk_i) begin
      if (rq) chk("read data", rdata, q.pop_front());
      rq <= req.rd;
      cyc++;
      if (cyc > 3000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(REG_STAT_OFS, 32'h0);
      rd(REG_INIT_OFS, 32'(INIT_RST_CYCLES_DEFAULT));
      rd(REG_CFG_OFS, {23'h0, RST_HIGH_DEFAULT, 8'(CLK_RATE_MHZ_DEFAULT)});
      wr(REG_CTRL_OFS, 32'h1);
      rd(REG_STAT_OFS, 32'h1);
      chk("edges running", 32'(edges > 0), 32'h1);
      e0 = edges;
      repeat (20) @(posedge clk_i);
      // default rate gives a half period of one system cycle
      chk("edges in 20", edges - e0, 32'd10);
      wr(REG_CTRL_OFS, 32'h4);
      rd(REG_STAT_OFS, 32'h3);
      chk("raised high", dr, 32'h1);
      wr(REG_CTRL_OFS, 32'h8);
      rd(REG_STAT_OFS, 32'h1);
      chk("released high", dr, 32'h0);
      wr(REG_CTRL_OFS, 32'h2);
      e0 = edges;
      rd(REG_STAT_OFS, 32'h0);
      repeat (10) @(posedge clk_i);
      chk("edges halted", edges - e0, 32'h0);
      chk("clock parked", dc, 32'h0);
      wr(REG_CFG_OFS, 32'(CLK_RATE_MHZ_DEFAULT));
      pol <= 1'b0;
      chk("idle low", dr, 32'h1);
      wr(REG_CTRL_OFS, 32'h4);
      chk("raised low", dr, 32'h0);
      wr(REG_CTRL_OFS, 32'h8);
      chk("released low", dr, 32'h1);
      wr(REG_INIT_OFS, 32'h6);
      rd(REG_STAT_OFS, 32'h2);
      chk("held low", dr, 32'h0);
      repeat (6) @(posedge clk_i);
      chk("hold ended", dr, 32'h1);
      rd(REG_STAT_OFS, 32'h0);
      repeat (20) @(posedge clk_i);
      chk("stays released", dr, 32'h1);
      repeat (4) begin
         s = xs(s);
         wr({s[3:2], s[1:0] | 2'h1}, s);
         rd({s[3:2], 2'h2}, 32'h0);
      end
      rd(REG_CFG_OFS, 32'(CLK_RATE_MHZ_DEFAULT));
      repeat (2) @(posedge clk_i);
      chk("reads pending", q.size(), 32'h0);
      results();
   end
endmodule // testbench
bind ckrs_top ckrs_top_asserts u_chk (.clk_i, .reset_i, .req_i, .rdata_o, .dut_clk_o, .dut_rst_o);
`default_nettype wire
